// [hw/cgc_clock_gen_control.sv]
// module: clock generation control top
`timescale 1ns/1ps
`default_nettype none
module cgc_clock_gen_control
    import cgc_pkg::*;
#(
    parameter int WAIT_W = CGC_WAIT_W,
    parameter int MAIN_WAIT_BASE = CGC_MAIN_WAIT_BASE,
    parameter int HOLD_CYC = 4
) (
    input wire logic mclk,
    input wire logic srst,
    // per-oscillator stop controls, 1 = stop
    input wire logic main_osc_stop,
    input wire logic sub_osc_stop,
    input wire logic fast_osc_stop,
    input wire logic mid_osc_stop,
    input wire logic slow_osc_stop,
    input wire logic ctrl_we,
    input wire logic [1:0] main_osc_mode_select,
    input wire logic [2:0] osc_wait_select,
    input wire logic fast_32m_sel,
    input wire logic [7:0] fast_osc_trim,
    input wire logic [7:0] mid_osc_trim,
    input wire logic [7:0] slow_osc_trim,
    input wire logic trim_we,
    input wire logic [2:0] sys_src_sel,
    input wire logic sys_src_we,
    input wire logic [2:0] clock_output_sel,
    input wire logic clock_output_en,
    input wire logic watchdog_opt_en,
    // status and oscillator controls
    output logic [4:0] osc_run,
    output logic [4:0] osc_stable_flags,
    output logic [2:0] sys_src_active,
    output logic sys_clk_gate,
    output logic switch_busy,
    output logic fast_32m_active,
    output logic [7:0] fast_trim_out,
    output logic [7:0] mid_trim_out,
    output logic [7:0] slow_trim_out,
    output logic main_pins_osc,
    output logic main_xin_hiz,
    output logic watchdog_run,
    output logic [2:0] clock_output_src,
    output logic clock_output_on
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [CGC_NUM_OSC-1:0] src_onehot(input logic [2:0] s);
        logic [CGC_NUM_OSC-1:0] r;
        r = '0;
        case (s)
            CGC_SRC_FAST: r[CGC_IDX_FAST] = 1'b1;
            CGC_SRC_MID: r[CGC_IDX_MID] = 1'b1;
            CGC_SRC_SLOW: r[CGC_IDX_SLOW] = 1'b1;
            CGC_SRC_MAIN: r[CGC_IDX_MAIN] = 1'b1;
            CGC_SRC_SUB: r[CGC_IDX_SUB] = 1'b1;
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic src_valid(input logic [2:0] s);
        return (s <= CGC_SRC_SUB);
    endfunction

    // ------------------------------------------------------------
    // oscillator stop registers
    // ------------------------------------------------------------
    logic [4:0] stop_q;
    logic [1:0] mode_q;
    logic [2:0] wsel_q;
    logic fast32_q;
    logic wdt_q;
    logic [4:0] run_d;
    logic [4:0] stable_w;
    logic [4:0] src_oh;
    cgc_sw_type sw_q;
    logic [2:0] tgt_q;

    // stop bits, 1 stops the oscillator
    always_ff @(posedge mclk) begin
        if (srst) begin
            stop_q <= CGC_STOP_RST;
        end else if (ctrl_we) begin
            stop_q[CGC_IDX_MAIN] <= main_osc_stop;
            stop_q[CGC_IDX_SUB] <= sub_osc_stop;
            stop_q[CGC_IDX_FAST] <= fast_osc_stop;
            stop_q[CGC_IDX_MID] <= mid_osc_stop;
            stop_q[CGC_IDX_SLOW] <= slow_osc_stop;
        end
    end

    // mode and wait only change while the main stop bit is set
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_q <= CGC_MAIN_MODE_RST;
            wsel_q <= CGC_WAIT_SEL_RST;
        end else if (ctrl_we && stop_q[CGC_IDX_MAIN]) begin
            mode_q <= main_osc_mode_select;
            wsel_q <= osc_wait_select;
        end
    end

    // speed only changes while the fast stop bit is set
    always_ff @(posedge mclk) begin
        if (srst) begin
            fast32_q <= CGC_FAST_32M_RST;
        end else if (ctrl_we && stop_q[CGC_IDX_FAST]) begin
            fast32_q <= fast_32m_sel;
        end
    end

    // watchdog enable caught from option memory after reset release
    logic wdt_cap_q;
    always_ff @(posedge mclk) begin
        if (srst) begin
            wdt_cap_q <= 1'b0;
            wdt_q <= 1'b0;
        end else if (!wdt_cap_q) begin
            wdt_cap_q <= 1'b1;
            wdt_q <= watchdog_opt_en;
        end
    end

    // a running source may not be stopped; a held target stays up until taken
    logic [2:0] act_q;
    always_comb begin
        run_d = ~stop_q | src_onehot(act_q);
        if (sw_q == CGC_SW_HOLD) begin
            run_d = run_d | src_oh;
        end
        run_d[CGC_IDX_SLOW] = run_d[CGC_IDX_SLOW] | wdt_q;
    end

    // ------------------------------------------------------------
    // stabilization waits
    // ------------------------------------------------------------
    logic [WAIT_W-1:0] wait_tab [CGC_NUM_OSC];
    always_comb begin
        wait_tab[CGC_IDX_FAST] = WAIT_W'(CGC_FAST_WAIT_CYC);
        wait_tab[CGC_IDX_MID] = WAIT_W'(CGC_MID_WAIT_CYC);
        wait_tab[CGC_IDX_SLOW] = WAIT_W'(CGC_SLOW_WAIT_CYC);
        wait_tab[CGC_IDX_MAIN] = WAIT_W'(MAIN_WAIT_BASE) << wsel_q;
        wait_tab[CGC_IDX_SUB] = WAIT_W'(CGC_SUB_WAIT_CYC);
    end

    genvar gi;
    generate
        for (gi = 0; gi < CGC_NUM_OSC; gi++) begin : g_wait
            cgc_osc_wait #(
                .WAIT_W(WAIT_W)
            ) u_wait (
                .mclk(mclk),
                .srst(srst),
                .run(run_d[gi]),
                .wait_cyc(wait_tab[gi]),
                .stable(stable_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // system clock source switch
    // ------------------------------------------------------------
    logic [7:0] hold_q;

    assign src_oh = src_onehot(tgt_q);

    // hold gates the clock so cycles stretch, never shorten
    always_ff @(posedge mclk) begin
        if (srst) begin
            sw_q <= CGC_SW_IDLE;
            act_q <= CGC_SRC_FAST;
            tgt_q <= CGC_SRC_FAST;
            hold_q <= 8'h00;
        end else begin
            case (sw_q)
                CGC_SW_IDLE: begin
                    if (sys_src_we && src_valid(sys_src_sel) && sys_src_sel != act_q) begin
                        tgt_q <= sys_src_sel;
                        sw_q <= CGC_SW_WAIT;
                    end
                end
                CGC_SW_WAIT: begin
                    if (|(src_oh & stable_w)) begin
                        hold_q <= 8'(HOLD_CYC);
                        sw_q <= CGC_SW_HOLD;
                    end
                end
                CGC_SW_HOLD: begin
                    if (hold_q == 8'h00) begin
                        act_q <= tgt_q;
                        sw_q <= CGC_SW_IDLE;
                    end else begin
                        hold_q <= hold_q - 8'h01;
                    end
                end
                default: sw_q <= CGC_SW_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // trimming registers
    // ------------------------------------------------------------
    // all three trims load together on one strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            fast_trim_out <= CGC_TRIM_RST;
            mid_trim_out <= CGC_TRIM_RST;
            slow_trim_out <= CGC_TRIM_RST;
        end else if (trim_we) begin
            fast_trim_out <= fast_osc_trim;
            mid_trim_out <= mid_osc_trim;
            slow_trim_out <= slow_osc_trim;
        end
    end

    // ------------------------------------------------------------
    // clock output selection
    // ------------------------------------------------------------
    // a stopped oscillator is never put on the pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            clock_output_src <= CGC_OUT_SEL_RST;
            clock_output_on <= 1'b0;
        end else begin
            clock_output_src <= clock_output_sel;
            clock_output_on <= clock_output_en && src_valid(clock_output_sel)
                && run_d[clock_output_sel];
        end
    end

    // ------------------------------------------------------------
    // oscillator status outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_run <= ~CGC_STOP_RST;
            osc_stable_flags <= 5'h00;
            fast_32m_active <= CGC_FAST_32M_RST;
        end else begin
            osc_run <= run_d;
            osc_stable_flags <= stable_w;
            fast_32m_active <= fast32_q;
        end
    end

    // ------------------------------------------------------------
    // switch status outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            sys_src_active <= CGC_SRC_FAST;
            sys_clk_gate <= 1'b1;
            switch_busy <= 1'b0;
        end else begin
            sys_src_active <= act_q;
            sys_clk_gate <= (sw_q != CGC_SW_HOLD);
            switch_busy <= (sw_q != CGC_SW_IDLE);
        end
    end

    // ------------------------------------------------------------
    // main oscillator pin and watchdog outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            main_pins_osc <= 1'b0;
            main_xin_hiz <= 1'b0;
            watchdog_run <= 1'b0;
        end else begin
            main_pins_osc <= !stop_q[CGC_IDX_MAIN];
            main_xin_hiz <= (mode_q == CGC_MAIN_MODE_EXT);
            watchdog_run <= wdt_q;
        end
    end

endmodule // cgc_clock_gen_control
`default_nettype wire

// [hw/cgc_pkg.sv]
// package: constants and types for the clock generation control block
package cgc_pkg;

    // ------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------
    localparam int CGC_SRC_W = 3;
    localparam logic [2:0] CGC_SRC_FAST = 3'h0;
    localparam logic [2:0] CGC_SRC_MID = 3'h1;
    localparam logic [2:0] CGC_SRC_SLOW = 3'h2;
    localparam logic [2:0] CGC_SRC_MAIN = 3'h3;
    localparam logic [2:0] CGC_SRC_SUB = 3'h4;
    localparam int CGC_NUM_OSC = 5;

    // ------------------------------------------------------------
    // oscillator indices in flag vectors
    // ------------------------------------------------------------
    localparam int CGC_IDX_FAST = 0;
    localparam int CGC_IDX_MID = 1;
    localparam int CGC_IDX_SLOW = 2;
    localparam int CGC_IDX_MAIN = 3;
    localparam int CGC_IDX_SUB = 4;

    // ------------------------------------------------------------
    // main oscillator mode and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CGC_MAIN_MODE_EXT = 2'h3;
    localparam logic [1:0] CGC_MAIN_MODE_RST = 2'h0;
    localparam logic [4:0] CGC_STOP_RST = 5'h1E;
    localparam logic CGC_FAST_32M_RST = 1'h1;
    localparam logic [7:0] CGC_TRIM_RST = 8'h80;
    localparam logic [2:0] CGC_OUT_SEL_RST = 3'h0;
    localparam logic [2:0] CGC_WAIT_SEL_RST = 3'h0;

    // ------------------------------------------------------------
    // stabilization waits
    // ------------------------------------------------------------
    localparam int CGC_WAIT_W = 20;
    localparam int CGC_FAST_WAIT_US = 10;
    localparam int CGC_CLK_MHZ = 125;
    localparam int CGC_FAST_WAIT_CYC = CGC_FAST_WAIT_US * CGC_CLK_MHZ;
    localparam int CGC_MID_WAIT_CYC = 16;
    localparam int CGC_SLOW_WAIT_CYC = 64;
    localparam int CGC_SUB_WAIT_CYC = 256;
    localparam int CGC_MAIN_WAIT_BASE = 1 << 10;

    // ------------------------------------------------------------
    // switch state machine (gray from idle to wait to hold; hold back to idle flips both bits)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CGC_SW_IDLE = 2'h0,
        CGC_SW_WAIT = 2'h1,
        CGC_SW_HOLD = 2'h3
    } cgc_sw_type;

endpackage

// [hw/cgc_osc_wait.sv]
// module: stabilization wait counter for one oscillator
`timescale 1ns/1ps
`default_nettype none
module cgc_osc_wait #(
    parameter int WAIT_W = 20
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic run,
    input wire logic [WAIT_W-1:0] wait_cyc,
    output logic stable
);
    logic [WAIT_W-1:0] cnt_q;

    // ------------------------------------------------------------
    // count up to wait_cyc and hold there while running, clear on stop
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst || !run) begin
            cnt_q <= '0;
        end else if (cnt_q < wait_cyc) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || !run) begin
            stable <= 1'b0;
        end else begin
            stable <= (cnt_q >= wait_cyc);
        end
    end
endmodule // cgc_osc_wait
`default_nettype wire

// [tb/cgc_checker_assertions.sv]
// checker: port assertions for the clock generation control top
`timescale 1ns/1ps
`default_nettype none
module cgc_checker
    import cgc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic sys_src_we,
    input wire logic [2:0] sys_src_sel,
    input wire logic trim_we,
    input wire logic [7:0] fast_osc_trim,
    input wire logic [7:0] mid_osc_trim,
    input wire logic [7:0] slow_osc_trim,
    input wire logic [2:0] clock_output_sel,
    input wire logic clock_output_en,
    input wire logic [4:0] osc_run,
    input wire logic [4:0] osc_stable_flags,
    input wire logic [2:0] sys_src_active,
    input wire logic sys_clk_gate,
    input wire logic switch_busy,
    input wire logic [7:0] fast_trim_out,
    input wire logic [7:0] mid_trim_out,
    input wire logic [7:0] slow_trim_out,
    input wire logic main_pins_osc,
    input wire logic main_xin_hiz,
    input wire logic watchdog_run
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    a_reset_src_fast: assert property ($fell(srst) |-> sys_src_active == CGC_SRC_FAST)
        else $error("source not fast after reset");
    a_reset_osc_off: assert property ($fell(srst) |-> osc_run[4:3] == 2'h0 && !osc_run[1]
        && osc_run[0] && !main_pins_osc && !main_xin_hiz) else $error("reset oscillator state");
    a_wdt_slow_on: assert property (watchdog_run |-> ##2 osc_run[CGC_IDX_SLOW])
        else $error("slow oscillator off with watchdog");
    a_flag_needs_run: assert property ((osc_stable_flags & ~$past(osc_stable_flags) & ~$past(osc_run)) == 5'h00)
        else $error("flag rose on stopped oscillator");
    a_mid_wait_min: assert property ($rose(osc_run[CGC_IDX_MID]) |-> !osc_stable_flags[CGC_IDX_MID] [*8])
        else $error("mid flag too early");
    a_switch_stable: assert property ($changed(sys_src_active) |-> osc_stable_flags[sys_src_active])
        else $error("switched to unstable source");
    a_switch_stretch: assert property ($changed(sys_src_active) |-> !$past(sys_clk_gate, 1) || !$past(sys_clk_gate, 2)
        || !$past(sys_clk_gate, 3) || !$past(sys_clk_gate, 4)) else $error("switch without stretch");
    a_switch_start: assert property (sys_src_we && !switch_busy && sys_src_sel <= CGC_SRC_SUB
        && sys_src_sel != sys_src_active |-> ##[1:2] switch_busy) else $error("switch not started");
    a_trim_load: assert property (trim_we |=> fast_trim_out == $past(fast_osc_trim)
        && mid_trim_out == $past(mid_osc_trim) && slow_trim_out == $past(slow_osc_trim)) else $error("trim");
endmodule // cgc_checker
bind cgc_clock_gen_control cgc_checker u_chk (.*);
`default_nettype wire

// [tb/tb.sv]
// testbench: self-checking bench for the clock generation control top
`timescale 1ns/1ps
`default_nettype none
module tb
    import cgc_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, ctrl_we = 1'b0, trim_we = 1'b0, sys_src_we = 1'b0;
    logic main_osc_stop = 1'b1, sub_osc_stop = 1'b1, fast_osc_stop = 1'b0;
    logic mid_osc_stop = 1'b1, slow_osc_stop = 1'b1, fast_32m_sel = 1'b1;
    logic clock_output_en = 1'b0, watchdog_opt_en = 1'b0, gap = 1'b0;
    logic [1:0] main_osc_mode_select = 2'h0;
    logic [2:0] osc_wait_select = 3'h0, sys_src_sel = 3'h0, clock_output_sel = 3'h0;
    logic [7:0] fast_osc_trim = 8'h80, mid_osc_trim = 8'h80, slow_osc_trim = 8'h80;
    logic [4:0] osc_run, osc_stable_flags;
    logic [2:0] sys_src_active, clock_output_src;
    logic [7:0] fast_trim_out, mid_trim_out, slow_trim_out;
    logic sys_clk_gate, switch_busy, fast_32m_active, main_pins_osc, main_xin_hiz;
    logic watchdog_run, clock_output_on;
    logic [11:0] q_exp [$];
    logic [11:0] e;
    logic [23:0] t;
    logic [2:0] srcs [3] = '{CGC_SRC_MID, CGC_SRC_MAIN, CGC_SRC_FAST};
    int mismatches = 0, checks = 0;
    always #4 mclk = ~mclk;
    cgc_clock_gen_control #(.MAIN_WAIT_BASE(4)) uut (.*);
    always @(posedge mclk) begin
        if (sys_src_we) begin
            gap <= 1'b0;
        end else if (sys_clk_gate === 1'b0) begin
            gap <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // watcher and helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] get(input logic [3:0] s);
        case (s)
            4'h0: get = {3'h0, osc_run};
            4'h1: get = {3'h0, osc_stable_flags};
            4'h2: get = {5'h00, sys_src_active};
            4'h3: get = {7'h00, fast_32m_active};
            4'h4: get = {7'h00, main_pins_osc};
            4'h5: get = {7'h00, main_xin_hiz};
            4'h6: get = {7'h00, watchdog_run};
            4'h7: get = {5'h00, clock_output_src};
            4'h8: get = {7'h00, clock_output_on};
            4'h9: get = fast_trim_out;
            4'hA: get = mid_trim_out;
            4'hB: get = slow_trim_out;
            4'hD: get = {7'h00, switch_busy};
            default: get = {7'h00, gap};
        endcase
    endfunction
    always @(posedge mclk) begin
        #2;
        while (q_exp.size() > 0) begin
            e = q_exp.pop_front();
            checks++;
            if (get(e[11:8]) !== e[7:0]) begin
                mismatches++;
                $display("MISMATCH t=%0t item %0d got %h exp %h", $time, e[11:8], get(e[11:8]), e[7:0]);
            end
        end
    end
    task automatic chk(input logic [3:0] s, input logic [7:0] v);
        q_exp.push_back({s, v});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        cyc(1);
        #3;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_hi(input int i, input int lim);
        int n;
        n = 0;
        while (!(i < 5 ? osc_stable_flags[i] === 1'b1 : switch_busy === 1'b0)) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > lim) begin
                mismatches++;
                $display("MISMATCH t=%0t wait %0d timed out", $time, i);
                tally_and_finish();
            end
        end
    endtask
    task automatic ctrl(input logic [4:0] s, input logic [1:0] md);
        @(posedge mclk);
        {sub_osc_stop, main_osc_stop, slow_osc_stop, mid_osc_stop, fast_osc_stop} <= s;
        main_osc_mode_select <= md;
        ctrl_we <= 1'b1;
        @(posedge mclk);
        ctrl_we <= 1'b0;
    endtask
    task automatic req(input logic [2:0] src);
        @(posedge mclk);
        sys_src_sel <= src;
        sys_src_we <= 1'b1;
        @(posedge mclk);
        sys_src_we <= 1'b0;
        cyc(3);
    endtask
    task automatic sw(input logic [2:0] src);
        req(src);
        wait_hi(5, 3000);
        cyc(2);
        chk(4'h2, {5'h00, src});
        chk(4'hC, 8'h01);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #700000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h00864013));
        cyc(12);
        srst <= 1'b0;
        @(posedge mclk);
        chk(4'h0, 8'h01);
        chk(4'h2, {5'h00, CGC_SRC_FAST});
        chk(4'h3, 8'h01);
        chk(4'h4, 8'h00);
        chk(4'h6, 8'h00);
        chk(4'h8, 8'h00);
        chk(4'h9, CGC_TRIM_RST);
        $display("test reset_defaults done");
        wait_hi(CGC_IDX_FAST, 2000);
        chk(4'h1, 8'h01);
        ctrl(5'h14, CGC_MAIN_MODE_EXT);
        wait_hi(CGC_IDX_MID, 100);
        wait_hi(CGC_IDX_MAIN, 100);
        chk(4'h0, 8'h0B);
        chk(4'h5, 8'h01);
        foreach (srcs[k]) sw(srcs[k]);
        req(3'h5);
        chk(4'hD, 8'h00);
        chk(4'h2, {5'h00, CGC_SRC_FAST});
        ctrl(5'h17, CGC_MAIN_MODE_EXT);
        cyc(3);
        chk(4'h0, 8'h09);
        chk(4'h1, 8'h09);
        fast_32m_sel <= 1'b0;
        ctrl(5'h17, CGC_MAIN_MODE_EXT);
        cyc(1);
        chk(4'h3, 8'h00);
        $display("test osc_switch done");
        t = 24'($urandom);
        @(posedge mclk);
        {slow_osc_trim, mid_osc_trim, fast_osc_trim} <= t;
        trim_we <= 1'b1;
        @(posedge mclk);
        trim_we <= 1'b0;
        @(posedge mclk);
        chk(4'h9, t[7:0]);
        chk(4'hA, t[15:8]);
        chk(4'hB, t[23:16]);
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk);
            clock_output_sel <= 3'(k);
            clock_output_en <= (k != 0);
            cyc(2);
            chk(4'h7, 8'(k));
            chk(4'h8, 8'(3'(k) == CGC_SRC_MAIN));
        end
        $display("test trim_clock_output done");
        @(posedge mclk);
        srst <= 1'b1;
        watchdog_opt_en <= 1'b1;
        cyc(12);
        srst <= 1'b0;
        cyc(4);
        chk(4'h6, 8'h01);
        chk(4'h0, 8'h05);
        $display("test watchdog done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
